// file: design/adc_out_defs.svh
// Purpose : Constants for the converter output coding block
// Assumes : Included by its bare name
// Notes   : Definitions only
`ifndef ADC_OUT_DEFS_SVH
`define ADC_OUT_DEFS_SVH

// ----------------------------------------
// Widths, reset values and coding constants
// ----------------------------------------
`define CODE_W          8
`define CODE_RESET      8'h00
`define CODE_ALL_ONES   8'hFF
`define CODE_ALL_ZEROS  8'h00
`define FLAG_RESET      1'b0

`endif

// file: design/adc_out_pkg.sv
// Purpose : Types for the converter output coding block
// Assumes : Header of constants is included first
// Notes   : Holds types only
`include "adc_out_defs.svh"

package adc_out_pkg;

  typedef logic [`CODE_W-1:0] code_t;

  // Coding applied to one sample
  typedef enum logic [1:0] {
    CODE_IN_RANGE,
    CODE_OVER_FLAGGED,
    CODE_OVER_SATURATED
  } coding_t;

endpackage

// file: design/adc_output_overrange_coding.sv
// Purpose : Output latches and overrange coding of an 8-bit flash converter
// Assumes : Sample strobe pair and suppress select come from outside the clk domain
// Notes   : Two-entry buffer absorbs short receiver stalls; a word pushed while it is full with no pop in that cycle is dropped and raises overrun
`timescale 1ns/1ns
`include "adc_out_defs.svh"

// Operation
// RULE1 - A new result is captured only on a rising edge of the sample strobe.
// RULE2 - The outside driver supplies the strobe as a true complementary pair.
// RULE3 - A floating or low suppress select means reporting enabled, grounded means inhibited.
// RULE4 - Enabled and over range gives flag 1 with an all-zero code.
// RULE5 - Inhibited and over range gives flag 0 with an all-ones code.
// RULE6 - The flag is high only when over range and enabled; in range the code is the result.
// RULE7 - Each sample appears at the outputs one strobe cycle after the edge that took it.
// RULE8 - The code is unsigned binary with bit 0 least significant.
module adc_output_overrange_coding
  import adc_out_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              strobe_p,
  input  wire logic              strobe_n,
  input  wire logic              overrange_suppress_select,
  input  wire logic [7:0]        sample_value,
  input  wire logic              sample_over_range,
  output logic      [7:0]        conversion_code,
  output logic                   overrange_flag,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic                   overrun
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Release is synchronised so no flop leaves reset a cycle ahead of another
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Stage one feeds stage two only; stages two and three are compared
  logic [2:0] sp_r, sp_nxt, sn_r, sn_nxt, sel_r, sel_nxt;
  logic       strobe_lvl_r, strobe_lvl_nxt;
  logic       enabled_r, enabled_nxt;
  logic       p_lvl, n_lvl;

  function automatic logic agreed(input logic [2:0] s, input logic held);
    agreed = (s[1] == s[2]) ? s[2] : held;
  endfunction

  always_comb begin
    sp_nxt  = {sp_r[1:0], strobe_p};
    sn_nxt  = {sn_r[1:0], strobe_n};
    sel_nxt = {sel_r[1:0], overrange_suppress_select};
    // RULE2 strobe pair check
    // A level counts only while both halves agree and are opposite
    p_lvl = agreed(sp_r, strobe_lvl_r);
    n_lvl = agreed(sn_r, !strobe_lvl_r);
    if (p_lvl != n_lvl)
      strobe_lvl_nxt = p_lvl;
    else
      strobe_lvl_nxt = strobe_lvl_r;
    // RULE3 select polarity
    // Select high means grounded: inhibited. Low or floating (pulled low) enables.
    // Four flops of delay cost nothing on a static strap
    enabled_nxt = !agreed(sel_r, !enabled_r);
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      // Idle pair is low/high, so no false edge follows reset
      sp_r         <= 3'h0;
      sn_r         <= 3'h7;
      sel_r        <= 3'h0;
      strobe_lvl_r <= 1'b0;
      enabled_r    <= 1'b1;
    end else begin
      sp_r         <= sp_nxt;
      sn_r         <= sn_nxt;
      sel_r        <= sel_nxt;
      strobe_lvl_r <= strobe_lvl_nxt;
      enabled_r    <= enabled_nxt;
    end
  end

  // ----------------------------------------
  // Sample capture and coding
  // ----------------------------------------
  logic    rise;
  code_t   cap_code_r, cap_code_nxt;
  coding_t cap_kind_r, cap_kind_nxt;
  logic    cap_valid_r, cap_valid_nxt;
  logic    push;
  logic    space;

  // A strobe phase shorter than two clk may be missed
  assign rise = strobe_lvl_nxt && !strobe_lvl_r;

  always_comb begin
    cap_code_nxt  = cap_code_r;
    cap_kind_nxt  = cap_kind_r;
    cap_valid_nxt = cap_valid_r;
    push          = 1'b0;
    // RULE1 capture on rise
    if (rise) begin
      cap_valid_nxt = 1'b1;
      // RULE8 binary code order
      cap_code_nxt  = sample_value;
      // Coding is fixed at capture, so a later select change cannot recode it
      if (!sample_over_range)
        cap_kind_nxt = CODE_IN_RANGE;
      else if (enabled_r)
        cap_kind_nxt = CODE_OVER_FLAGGED;
      else
        cap_kind_nxt = CODE_OVER_SATURATED;
    end
    // RULE7 one-stage pipeline
    // The previous sample moves on when the next edge arrives
    if (rise && cap_valid_r)
      push = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cap_code_r  <= `CODE_RESET;
      cap_kind_r  <= CODE_IN_RANGE;
      cap_valid_r <= 1'b0;
    end else begin
      cap_code_r  <= cap_code_nxt;
      cap_kind_r  <= cap_kind_nxt;
      cap_valid_r <= cap_valid_nxt;
    end
  end

  // ----------------------------------------
  // Output coding
  // ----------------------------------------
  function automatic code_t coded(input coding_t k, input code_t v);
    case (k)
      CODE_IN_RANGE:       coded = v;
      // RULE4 flagged zeros
      CODE_OVER_FLAGGED:   coded = `CODE_ALL_ZEROS;
      // RULE5 saturated ones
      CODE_OVER_SATURATED: coded = `CODE_ALL_ONES;
      default:             coded = v;
    endcase
  endfunction

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  // Only two entries: a stall longer than two strobe periods drops the
  // sample captured one strobe before the newest and raises overrun, since a flash converter cannot pause.
  logic [8:0] buf_r [2];
  logic [8:0] buf_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic [7:0] code_nxt;
  logic       flag_nxt, valid_nxt, overrun_nxt;
  logic       pop;
  logic [8:0] word;

  // Slot 0 is always the head; slot 1 fills only behind it
  assign space = (cnt_r != 2'd2);

  always_comb begin
    // RULE6 flag only when enabled
    word        = {(cap_kind_r == CODE_OVER_FLAGGED), coded(cap_kind_r, cap_code_r)};
    buf_nxt[0]  = buf_r[0];
    buf_nxt[1]  = buf_r[1];
    cnt_nxt     = cnt_r;
    overrun_nxt = overrun;
    // A pop and a push may fall in one cycle; the pop is applied first
    pop         = out_valid && out_ready;
    if (pop) begin
      buf_nxt[0] = buf_r[1];
      cnt_nxt    = cnt_r - 2'd1;
    end
    if (push && (space || pop)) begin
      buf_nxt[cnt_nxt[0]] = word;
      cnt_nxt             = cnt_nxt + 2'd1;
    end else if (push) begin
      // Sticky until reset: the lost word cannot be recovered
      overrun_nxt = 1'b1;
    end
    valid_nxt = (cnt_nxt != 2'd0);
    code_nxt  = buf_nxt[0][7:0];
    // Stale slots behind an empty buffer never show a flag
    flag_nxt  = buf_nxt[0][8] && valid_nxt;
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      buf_r[0]        <= 9'h000;
      buf_r[1]        <= 9'h000;
      cnt_r           <= 2'h0;
      conversion_code <= `CODE_RESET;
      overrange_flag  <= `FLAG_RESET;
      out_valid       <= 1'b0;
      overrun         <= 1'b0;
    end else begin
      buf_r[0]        <= buf_nxt[0];
      buf_r[1]        <= buf_nxt[1];
      cnt_r           <= cnt_nxt;
      conversion_code <= code_nxt;
      overrange_flag  <= flag_nxt;
      out_valid       <= valid_nxt;
      overrun         <= overrun_nxt;
    end
  end

endmodule

// file: testbench/adc_sink_model.sv
// Purpose: downstream capture stub
// Assumes: stall comes from the bench
// Notes: ready follows stall one clk later, on the falling edge
`timescale 1ns/1ns
module adc_sink_model(
  input  wire logic clk,
  input  wire logic stall,
  output logic      out_ready
);
  logic stall_q = 1'b0;
  // Stall is taken on the rising edge and answered on the falling one,
  // so ready never moves in the time step of an edge that samples it
  always @(posedge clk) stall_q <= stall;
  always @(negedge clk) out_ready <= !stall_q;
endmodule

// file: testbench/adc_output_overrange_coding_properties.sv
// Purpose: port checks
// Assumes: strobe halves held 8 clk
// Notes: select only moves with the buffer empty
`timescale 1ns/1ns
module adc_out_checker(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       strobe_p,
  input wire logic       strobe_n,
  input wire logic       overrange_suppress_select,
  input wire logic [7:0] conversion_code,
  input wire logic       overrange_flag,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic       overrun
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rise; $past(strobe_p, 2) && !$past(strobe_n, 2); endsequence
  sequence s_stall; out_valid && !out_ready; endsequence
  AST_EDGE: assert property ($rose(out_valid) |-> s_rise)
    else $error("word without strobe rise");
  AST_QUIET: assert property ($stable(strobe_p) [*8] ##0 !out_valid |=> !out_valid)
    else $error("word while strobe idle");
  AST_HOLD: assert property (s_stall |=> out_valid && $stable(conversion_code) && $stable(overrange_flag))
    else $error("head lost during stall");
  AST_ZERO: assert property (overrange_flag |-> conversion_code == 8'h00)
    else $error("flag with nonzero code");
  AST_INH: assert property (out_valid && overrange_suppress_select |-> !overrange_flag)
    else $error("flag while inhibited");
  AST_FLAGV: assert property ($rose(overrange_flag) |-> out_valid)
    else $error("flag without word");
  AST_RST: assert property (disable iff (1'b0) !reset_n |=> !out_valid && !overrun)
    else $error("output during reset");
endmodule
bind adc_output_overrange_coding adc_out_checker i_adc_out_checker(.clk, .reset_n, .strobe_p,
  .strobe_n, .overrange_suppress_select, .conversion_code, .overrange_flag, .out_valid,
  .out_ready, .overrun);

// file: testbench/adc_output_overrange_coding_tb_top.sv
// Purpose: bench for output coding
// Assumes: strobe 8 clk high, 8 low
// Notes: each word pops against a queue
`timescale 1ns/1ns
module adc_output_overrange_coding_tb_top;
  logic clk = 0, reset_n = 0, strobe_p = 0, strobe_n = 1, stall = 0;
  logic overrange_suppress_select = 0, sample_over_range = 0;
  logic [7:0] sample_value = 8'h00, conversion_code;
  logic overrange_flag, out_valid, out_ready, overrun;
  int num_errors = 0, check_count = 0;
  logic [8:0] exp_q[$];
  always #4 clk = ~clk;
  adc_output_overrange_coding i_adc_output_overrange_coding(.clk, .reset_n, .strobe_p,
    .strobe_n, .overrange_suppress_select, .sample_value, .sample_over_range,
    .conversion_code, .overrange_flag, .out_valid, .out_ready, .overrun);
  adc_sink_model i_adc_sink_model(.clk, .stall, .out_ready);
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk) if (reset_n && out_valid === 1'b1 && out_ready === 1'b1)
    chk({overrange_flag, conversion_code}, exp_q.size() ? exp_q.pop_front() : 'x);
  task automatic strobe(input logic [7:0] v, input logic o, input logic keep = 1);
    sample_value = v;
    sample_over_range = o;
    strobe_p = 1;
    strobe_n = 0;
    repeat (8) @(negedge clk);
    strobe_p = 0;
    strobe_n = 1;
    repeat (8) @(negedge clk);
    if (keep) exp_q.push_back(o ? (overrange_suppress_select ? 9'h0FF : 9'h100) : {1'b0, v});
  endtask
  task automatic wait_q(input int k);
    for (int n = 0; n < 50 && exp_q.size() > k; n++) @(negedge clk);
    if (exp_q.size() > k) begin
      num_errors++;
      $display("[ERR] t=%0t pending=%h limit=%h", $time, exp_q.size(), k);
    end
  endtask
  task automatic t_codes;
    strobe(8'h01, 0);
    strobe(8'h80, 0);
    strobe(8'hFE, 0);
    strobe(8'h33, 1);
    strobe(8'h5A, 0);
    wait_q(1);
    overrange_suppress_select = 1;
    repeat (8) @(negedge clk);
    strobe(8'hC3, 1);
    strobe(8'h00, 0);
    wait_q(1);
    $display("t_codes done");
  endtask
  task automatic t_stall;
    stall = 1;
    strobe(8'h11, 0);
    strobe(8'h22, 0, 0);
    strobe(8'h44, 0);
    chk({8'h00, out_valid}, 9'h001);
    chk({overrange_flag, conversion_code}, 9'h000);
    chk({8'h00, overrun}, 9'h001);
    stall = 0;
    wait_q(1);
    $display("t_stall done");
  endtask
  task automatic t_bad;
    strobe_p = 1;
    repeat (8) @(negedge clk);
    strobe_p = 0;
    repeat (8) @(negedge clk);
    strobe(8'h66, 0, 0);
    wait_q(0);
    chk(9'(exp_q.size()), 9'h000);
    $display("t_bad done");
  endtask
  // Mid-run reset clears the sticky overrun and the pending capture
  task automatic t_reset;
    reset_n = 0;
    repeat (2) @(negedge clk);
    reset_n = 1;
    chk({7'h00, out_valid, overrun}, 9'h000);
    repeat (5) @(negedge clk);
    chk({7'h00, out_valid, overrun}, 9'h000);
    strobe(8'h77, 0);
    strobe(8'h0F, 0, 0);
    wait_q(0);
    $display("t_reset done");
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1;
    repeat (5) @(negedge clk);
    t_codes;
    t_stall;
    t_bad;
    t_reset;
    complete_run;
  end
  // About ten times the expected run of some 250 clk
  initial begin
    #20000;
    num_errors++;
    complete_run;
  end
endmodule
